/* File: pms_pkg.sv */
// package of constants for the power mode supervisor
package pms_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int REG_SETTLE_NS = 2000;
  localparam int CLK_SETTLE_NS = 500;
  localparam int REG_SETTLE_CYC = (REG_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CLK_SETTLE_CYC = (CLK_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  // ****************************************
  // peripheral vector positions
  // ****************************************
  localparam int NPER = 19;
  localparam int P_BROWN = 0;
  localparam int P_WATCH = 1;
  localparam int P_WDG = 4;
  localparam int P_GPIO = 14;
  localparam int P_DMA = 15;
  localparam int P_RADIO = 16;
  localparam int NWK = 22;
  localparam int W_RSTPIN = 19;
  localparam int W_ANYIO = 20;
  localparam int W_WAKEPIN = 21;
  // ****************************************
  // active peripheral sets per mode
  // ****************************************
  localparam logic [NPER-1:0] ACT_ALL = 19'h7FFFF;
  localparam logic [NPER-1:0] ACT_NORADIO = 19'h6FFFF;
  localparam logic [NPER-1:0] ACT_STOP0 = 19'h3FFFF;
  localparam logic [NPER-1:0] ACT_STOP0_R2 = 19'h2FFFF;
  localparam logic [NPER-1:0] ACT_STOP1 = 19'h07FFF;
  localparam logic [NPER-1:0] ACT_STOP2 = 19'h05B7F;
  localparam logic [NPER-1:0] ACT_STOP3 = 19'h04013;
  localparam logic [NPER-1:0] ACT_STBYRET = 19'h0003D;
  localparam logic [NPER-1:0] ACT_STBY = 19'h00011;
  // ****************************************
  // wake source sets per mode
  // ****************************************
  localparam logic [NWK-1:0] WK_ALL = 22'h3FFFFF;
  localparam logic [NWK-1:0] WK_STOP0 = 22'h3BBFFF;
  localparam logic [NWK-1:0] WK_STOP0_R2 = 22'h3ABFFF;
  localparam logic [NWK-1:0] WK_STOP1 = 22'h383FFF;
  localparam logic [NWK-1:0] WK_STOP2 = 22'h381B7F;
  localparam logic [NWK-1:0] WK_STOP3 = 22'h200010;
  localparam logic [NWK-1:0] WK_STBYRET = 22'h28003D;
  localparam logic [NWK-1:0] WK_STBY = 22'h280011;
  // ****************************************
  // mode select codes, ranges, thresholds
  // ****************************************
  localparam logic [2:0] SEL_SLEEP = 3'h0;
  localparam logic [2:0] SEL_STOP0 = 3'h1;
  localparam logic [2:0] SEL_STOP1 = 3'h2;
  localparam logic [2:0] SEL_STOP2 = 3'h3;
  localparam logic [2:0] SEL_STOP3 = 3'h4;
  localparam logic [2:0] SEL_STBYRET = 3'h5;
  localparam logic [2:0] SEL_STBY = 3'h6;
  localparam logic [1:0] RANGE_1 = 2'h0;
  localparam logic [1:0] RANGE_1P5 = 2'h1;
  localparam logic [1:0] RANGE_2 = 2'h2;
  localparam logic [2:0] BROWN_LOWEST = 3'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  typedef enum logic [3:0] {
    M_RUN, M_SLEEP, M_STOP0, M_STOP1, M_STOP2, M_STOP3, M_STBYRET, M_STBY, M_RESTORE
  } pms_mode_e;
endpackage

/* File: pms_sup_if.sv */
// interface between mode sequencer and supply supervisor
`timescale 1ns/1ps
interface pms_sup_if;
  logic belowBrown;
  logic belowWatch;
  logic [2:0] optThreshold;
  logic optValid;
  logic watchEnable;
  logic [1:0] watchEdgeSel;
  logic watchIrqClear;
  logic brownHold;
  logic [2:0] brownThreshold;
  logic watchIrq;
  modport sup (
    input belowBrown, belowWatch, optThreshold, optValid, watchEnable, watchEdgeSel,
    input watchIrqClear,
    output brownHold, brownThreshold, watchIrq
  );
  modport ctl (
    output belowBrown, belowWatch, optThreshold, optValid, watchEnable, watchEdgeSel,
    output watchIrqClear,
    input brownHold, brownThreshold, watchIrq
  );
endinterface

/* File: pms_supply_watch.sv */
// brown-out hold, threshold selection and supply level watcher
`timescale 1ns/1ps
module pms_supply_watch
  import pms_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  pms_sup_if.sup sup
);
  logic prevBelow;
  logic [2:0] threshold;
  logic irq;
  wire fellBelow = sup.belowWatch && !prevBelow;
  wire roseAbove = !sup.belowWatch && prevBelow;
  // RULE4 edge selected event
  wire watchEvent = sup.watchEnable &&
    ((fellBelow && sup.watchEdgeSel[0]) || (roseAbove && sup.watchEdgeSel[1]));
  // RULE1 hold while supply low
  assign sup.brownHold = sup.belowBrown;
  assign sup.brownThreshold = threshold;
  assign sup.watchIrq = irq;
  // RULE2 lowest level until options load
  always_ff @(posedge mclk)
  begin
    if (reset)
      threshold <= BROWN_LOWEST;
    else if (sup.optValid)
      threshold <= sup.optThreshold;
  end
  // set wins over clear
  always_ff @(posedge mclk)
  begin
    if (reset || sup.brownHold)
    begin
      prevBelow <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      prevBelow <= sup.belowWatch;
      irq <= watchEvent || (irq && !sup.watchIrqClear);
    end
  end
  a_watch_event_sets: assert property (@(posedge mclk) disable iff (reset) // RULE4
    (watchEvent && !sup.brownHold) |=> irq)
    else $error("watch event did not raise interrupt");
  a_watch_needs_enable: assert property (@(posedge mclk) disable iff (reset) // RULE4
    (!irq && !sup.watchEnable) |=> !irq)
    else $error("watch interrupt raised while disabled");
endmodule // pms_supply_watch

/* File: pms_restore_seq.sv */
// wake-up restore sequence: regulator, clock, peripherals, then cpu
`timescale 1ns/1ps
module pms_restore_seq
  import pms_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  output logic regUp,
  output logic clkUp,
  output logic done
);
  typedef enum logic [1:0] {R_IDLE, R_REG, R_CLK, R_DONE} pms_rst_e;
  pms_rst_e state;
  logic [CNT_W-1:0] count;
  wire countEnd = (count == '0);
  // RULE26 restore order
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= R_IDLE;
      count <= '0;
    end
    else
    begin
      case (state)
        R_IDLE:
          if (start)
          begin
            state <= R_REG;
            count <= CNT_W'(REG_SETTLE_CYC - 1);
          end
        R_REG:
          if (countEnd)
          begin
            state <= R_CLK;
            count <= CNT_W'(CLK_SETTLE_CYC - 1);
          end
          else
            count <= count - 1'b1;
        R_CLK:
          if (countEnd)
            state <= R_DONE;
          else
            count <= count - 1'b1;
        R_DONE: state <= R_IDLE;
        default: state <= R_IDLE;
      endcase
    end
  end
  assign regUp = (state != R_IDLE);
  assign clkUp = (state == R_CLK) || (state == R_DONE);
  assign done = (state == R_DONE);
  a_restore_after_clock: assert property (@(posedge mclk) disable iff (reset) // RULE26
    done |-> $past(clkUp) && regUp)
    else $error("restore finished before clock was up");
endmodule // pms_restore_seq

/* File: pms_power_supervisor.sv */
// power mode supervisor top: modes, gating, wake-up and supply control
// ****************************************
// Functional notes
// RULE1 - hold whole chip in reset while supply below brown-out level
// RULE2 - power-on threshold is lowest level; higher ones from option settings
// RULE3 - brown-out detector stays active in every mode
// RULE4 - software-enabled supply watcher interrupts on fall, rise or both
// RULE5 - software keeps clocks at 64 MHz in ranges 1, 1.5, 16 MHz range 2
// RULE6 - run and sleep: radio only in range 1, all else usable
// RULE7 - sleep stops cpu only; any interrupt or event wakes it
// RULE8 - stop 0 at range 2 drops radio; cpu and flash off
// RULE9 - stop 1 keeps listed low-power peripherals; others freeze
// RULE10 - stop 2 keeps smaller set; others powered down
// RULE11 - stop 3 keeps brown-out, watcher, gpio, watchdog; wake pin or watchdog
// RULE12 - standby retention: cpu off, sram may stay; limited wake sources
// RULE13 - standby: regulator and sram off; reset pin, brown-out, watchdog, wake pin
// RULE14 - in both standby modes each pad takes its software state
// RULE15 - stop 1 to 3 and retention: main regulator off, low-power one on
// RULE16 - flash may power down and clock gate when running from sram
// RULE17 - in sleep both sram bank clocks gate independently
// RULE18 - each sram can be switched off where sram is retained
// RULE19 - stop 0 turns fast rc on while a peripheral requests it
// RULE20 - low-power dma runs in stop 0 and may raise wake interrupt
// RULE21 - stop mode peripherals may request bus clock or wake
// RULE22 - core supply source switches either way while running, no reset
// RULE23 - after stop or standby wake the system clock is fast rc
// RULE24 - bus clock request in stop 1 enters stop 0, returns when none
// RULE25 - start in run after reset
// RULE26 - restore regulator, clocks, peripherals before cpu resumes
// ****************************************
`timescale 1ns/1ps
module pms_power_supervisor
  import pms_pkg::*;
#(
  parameter int NIO = 8
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic supplyBelowBrown,
  input wire logic supplyBelowWatch,
  input wire logic [2:0] optionThreshold,
  input wire logic optionValid,
  input wire logic watchEnable,
  input wire logic [1:0] watchEdgeSel,
  input wire logic watchIrqClear,
  input wire logic [2:0] lowPowerSel,
  input wire logic enterLowPower,
  input wire logic [1:0] rangeSel,
  input wire logic anyInterrupt,
  input wire logic [NWK-1:0] wakeSources,
  input wire logic [NPER-1:0] busClkReq,
  input wire logic [NPER-1:0] kernelClkReq,
  input wire logic execFromRam,
  input wire logic flashSleepReq,
  input wire logic [1:0] ramClkOff,
  input wire logic [1:0] ramPowerOff,
  input wire logic [2*NIO-1:0] ioStandbyCfg,
  input wire logic useSwitcher,
  output logic chipReset,
  output logic [2:0] brownThreshold,
  output logic watchIrq,
  output logic [3:0] modeState,
  output logic [1:0] coreRange,
  output logic mainRegOn,
  output logic lowPowerRegOn,
  output logic switcherOn,
  output logic linearOn,
  output logic cpuClkOn,
  output logic cpuPowerOn,
  output logic flashPowerOn,
  output logic flashClkOn,
  output logic [1:0] ramClkOn,
  output logic [1:0] ramPowerOn,
  output logic [NPER-1:0] periphActive,
  output logic [NPER-1:0] periphFrozen,
  output logic [NPER-1:0] periphPowerOn,
  output logic fastRcOn,
  output logic sysClkFastRc,
  output logic [2*NIO-1:0] ioPadState,
  output logic ioStandbyHold
);
  pms_mode_e mode;
  pms_mode_e next_mode;
  logic autoStop0;
  logic next_autoStop0;
  logic [1:0] rangeReg;
  logic restoreStart;
  logic regUp;
  logic clkUp;
  logic restoreDone;
  logic switcherSel;
  logic handover;

  // ****************************************
  // mode tables
  // ****************************************
  function automatic logic [NPER-1:0] activeSet(input pms_mode_e m, input logic [1:0] r);
    logic [NPER-1:0] s;
    s = '0;
    case (m)
      // RULE6 radio only in range 1
      M_RUN, M_SLEEP, M_RESTORE: s = (r == RANGE_1) ? ACT_ALL : ACT_NORADIO;
      // RULE8 stop 0 at range 2 loses radio
      M_STOP0: s = (r == RANGE_1) ? ACT_STOP0 : ACT_STOP0_R2;
      // RULE9 stop 1 set
      M_STOP1: s = ACT_STOP1;
      // RULE10 stop 2 set
      M_STOP2: s = ACT_STOP2;
      // RULE11 stop 3 set
      M_STOP3: s = ACT_STOP3;
      M_STBYRET: s = ACT_STBYRET;
      M_STBY: s = ACT_STBY;
      default: s = ACT_ALL;
    endcase
    return s;
  endfunction

  function automatic logic [NWK-1:0] wakeSet(input pms_mode_e m, input logic [1:0] r);
    logic [NWK-1:0] s;
    s = '0;
    case (m)
      M_SLEEP: s = WK_ALL;
      M_STOP0: s = (r == RANGE_1) ? WK_STOP0 : WK_STOP0_R2;
      M_STOP1: s = WK_STOP1;
      M_STOP2: s = WK_STOP2;
      // RULE11 wake pin or watchdog only
      M_STOP3: s = WK_STOP3;
      // RULE12 retention wake set
      M_STBYRET: s = WK_STBYRET;
      // RULE13 standby wake set
      M_STBY: s = WK_STBY;
      default: s = '0;
    endcase
    return s;
  endfunction

  // ****************************************
  // supply supervision
  // ****************************************
  pms_sup_if supBus ();
  assign supBus.belowBrown = supplyBelowBrown;
  assign supBus.belowWatch = supplyBelowWatch;
  assign supBus.optThreshold = optionThreshold;
  assign supBus.optValid = optionValid;
  assign supBus.watchEnable = watchEnable;
  assign supBus.watchEdgeSel = watchEdgeSel;
  assign supBus.watchIrqClear = watchIrqClear;

  pms_supply_watch u_supply (
    .mclk(mclk),
    .reset(reset),
    .sup(supBus)
  );

  // RULE1 chip reset from brown-out, no external help
  assign chipReset = reset || supBus.brownHold;
  assign brownThreshold = supBus.brownThreshold;
  assign watchIrq = supBus.watchIrq;

  // ****************************************
  // wake and request decode
  // ****************************************
  wire [NPER-1:0] modeActive = activeSet(mode, rangeReg);
  wire [NWK-1:0] modeWake = wakeSet(mode, rangeReg);
  // RULE21 only running peripherals may request or wake
  wire [NPER-1:0] busReqLive = busClkReq & modeActive;
  wire [NPER-1:0] kerReqLive = kernelClkReq & modeActive;
  wire anyBusReq = |busReqLive;
  wire [NWK-1:0] wakeLive = {wakeSources[NWK-1:NPER], wakeSources[NPER-1:0] & modeActive};
  // RULE7 sleep also wakes on any interrupt
  wire wakeHit = (|(wakeLive & modeWake)) || ((mode == M_SLEEP) && anyInterrupt);
  wire inStop = (mode == M_STOP0) || (mode == M_STOP1) || (mode == M_STOP2) ||
    (mode == M_STOP3);
  wire inStandby = (mode == M_STBYRET) || (mode == M_STBY);
  wire [NPER-1:0] stop2Kept = ACT_STOP2 & ~ACT_STOP3;

  // ****************************************
  // mode sequencer
  // ****************************************
  always_comb
  begin
    next_mode = mode;
    next_autoStop0 = autoStop0;
    restoreStart = 1'b0;
    case (mode)
      M_RUN:
        if (enterLowPower)
        begin
          next_autoStop0 = 1'b0;
          case (lowPowerSel)
            SEL_SLEEP: next_mode = M_SLEEP;
            SEL_STOP0: next_mode = M_STOP0;
            SEL_STOP1: next_mode = M_STOP1;
            SEL_STOP2: next_mode = M_STOP2;
            SEL_STOP3: next_mode = M_STOP3;
            SEL_STBYRET: next_mode = M_STBYRET;
            SEL_STBY: next_mode = M_STBY;
            default: next_mode = M_RUN;
          endcase
        end
      M_SLEEP:
        // RULE7 cpu stays powered, only clock returns
        if (wakeHit)
          next_mode = M_RUN;
      M_STOP0:
        if (wakeHit)
        begin
          next_mode = M_RESTORE;
          next_autoStop0 = 1'b0;
          restoreStart = 1'b1;
        end
        // RULE24 back to stop 1 once requests end
        else if (autoStop0 && !anyBusReq)
        begin
          next_mode = M_STOP1;
          next_autoStop0 = 1'b0;
        end
      M_STOP1:
        if (wakeHit)
        begin
          next_mode = M_RESTORE;
          restoreStart = 1'b1;
        end
        // RULE24 bus clock request enters stop 0
        else if (anyBusReq)
        begin
          next_mode = M_STOP0;
          next_autoStop0 = 1'b1;
        end
      M_STOP2, M_STOP3, M_STBYRET, M_STBY:
        if (wakeHit)
        begin
          next_mode = M_RESTORE;
          restoreStart = 1'b1;
        end
      // RULE26 cpu waits for restore
      M_RESTORE:
        if (restoreDone)
          next_mode = M_RUN;
      default: next_mode = M_RUN;
    endcase
  end

  // RULE25 run after reset or brown-out
  always_ff @(posedge mclk)
  begin
    if (chipReset)
    begin
      mode <= M_RUN;
      autoStop0 <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      autoStop0 <= next_autoStop0;
    end
  end

  // range changes only while running
  always_ff @(posedge mclk)
  begin
    if (chipReset)
      rangeReg <= RANGE_1;
    else if (mode == M_RUN)
      rangeReg <= rangeSel;
  end

  // RULE23 fast rc is system clock after any stop or standby wake
  always_ff @(posedge mclk)
  begin
    if (chipReset)
      sysClkFastRc <= 1'b1;
    else if (mode == M_RESTORE)
      sysClkFastRc <= 1'b1;
    else if (mode == M_RUN && enterLowPower)
      sysClkFastRc <= 1'b0;
  end

  pms_restore_seq u_restore (
    .mclk(mclk),
    .reset(chipReset),
    .start(restoreStart),
    .regUp(regUp),
    .clkUp(clkUp),
    .done(restoreDone)
  );

  // ****************************************
  // core supply source
  // ****************************************
  // RULE22 both stages overlap one cycle so the core never drops
  always_ff @(posedge mclk)
  begin
    if (chipReset)
    begin
      switcherSel <= 1'b0;
      handover <= 1'b0;
    end
    else
    begin
      switcherSel <= useSwitcher;
      handover <= (useSwitcher != switcherSel);
    end
  end

  // ****************************************
  // power and clock outputs
  // ****************************************
  wire awake = (mode == M_RUN) || (mode == M_SLEEP);
  wire lowPowerReg = (mode == M_STOP1) || (mode == M_STOP2) || (mode == M_STOP3) ||
    (mode == M_STBYRET);
  wire regulatorOn = (mode != M_STBY) || regUp;
  // RULE15 low-power regulator in deep stop and retention
  assign mainRegOn = (awake || mode == M_STOP0) || regUp;
  assign lowPowerRegOn = lowPowerReg && !regUp;
  assign switcherOn = regulatorOn && (switcherSel || handover);
  assign linearOn = regulatorOn && (!switcherSel || handover);
  assign modeState = mode;
  assign coreRange = rangeReg;
  // RULE7 cpu clock stops in sleep
  assign cpuClkOn = (mode == M_RUN);
  // RULE12 cpu unpowered in both standby modes
  assign cpuPowerOn = !inStandby || (mode == M_RESTORE);
  // RULE16 in run and sleep, flash sleeps only while code runs from sram; off in every other mode
  assign flashPowerOn = awake && !(execFromRam && flashSleepReq);
  assign flashClkOn = flashPowerOn;
  // RULE17 bank clocks gate independently in sleep
  assign ramClkOn = awake ? ((mode == M_SLEEP) ? ~ramClkOff : 2'h3) : 2'h0;
  // RULE18 per-bank power off where retained
  // RULE13 no sram in standby
  assign ramPowerOn = (mode == M_STBY) ? 2'h0 :
    ((inStop || mode == M_STBYRET) ? ~ramPowerOff : 2'h3);
  // RULE3 brown-out bit is set in every active set
  // RULE20 dma active in stop 0 through its set
  // brown-out and watchdog stay up while the restore waits for its clock
  assign periphActive = (mode == M_RESTORE && !clkUp) ? ACT_STBY : modeActive;
  // RULE9 frozen parts keep state with clock stopped
  // RULE11 stop 2 leftovers freeze in stop 3
  assign periphFrozen = ((mode == M_STOP0) || (mode == M_STOP1)) ? ~modeActive :
    ((mode == M_STOP3) ? stop2Kept : '0);
  // RULE10 beyond the stop 2 set all is unpowered
  assign periphPowerOn = ((mode == M_STOP2) || (mode == M_STOP3)) ? ACT_STOP2 :
    (inStandby ? modeActive : ACT_ALL);
  // RULE19 fast rc on while a peripheral asks
  assign fastRcOn = awake || clkUp ||
    (((mode == M_STOP0) || (mode == M_STOP1) || (mode == M_STOP2)) &&
    ((|kerReqLive) || anyBusReq));
  // RULE14 pads take software chosen state in standby
  assign ioStandbyHold = inStandby;
  assign ioPadState = inStandby ? ioStandbyCfg : '0;

  // ****************************************
  // checks
  // ****************************************
  a_brown_holds_reset: assert property (@(posedge mclk) // RULE1
    supplyBelowBrown |-> chipReset ##1 (mode == M_RUN && !watchIrq))
    else $error("chip not held in reset during brown-out");
  a_reset_gives_run: assert property (@(posedge mclk) // RULE25
    chipReset |=> mode == M_RUN)
    else $error("mode not run after reset");
  a_brown_always_on: assert property (@(posedge mclk) disable iff (chipReset) // RULE3
    periphActive[P_BROWN])
    else $error("brown-out detector inactive");
  a_radio_range_one: assert property (@(posedge mclk) disable iff (chipReset) // RULE6
    periphActive[P_RADIO] |-> rangeReg == RANGE_1)
    else $error("radio active outside range 1");
  a_stop1_bus_req: assert property (@(posedge mclk) disable iff (chipReset) // RULE24
    (mode == M_STOP1 && anyBusReq && !wakeHit) |=> mode == M_STOP0 && autoStop0)
    else $error("bus clock request did not enter stop 0");
  a_stop3_wake_only: assert property (@(posedge mclk) disable iff (chipReset) // RULE11
    (mode == M_STOP3 && !wakeSources[W_WAKEPIN] && !wakeSources[P_WDG]) |=> mode == M_STOP3)
    else $error("stop 3 left without a permitted source");
  a_deep_regulator: assert property (@(posedge mclk) disable iff (chipReset) // RULE15
    (lowPowerReg && !regUp) |-> !mainRegOn && lowPowerRegOn)
    else $error("wrong regulator in deep stop");
  a_wake_fast_clock: assert property (@(posedge mclk) disable iff (chipReset) // RULE23
    (mode == M_RESTORE && restoreDone) |=> mode == M_RUN && sysClkFastRc)
    else $error("wake did not resume on fast rc");
  a_cpu_after_restore: assert property (@(posedge mclk) disable iff (chipReset) // RULE26
    (inStop && wakeHit && mode != M_SLEEP) |=> !cpuClkOn [*2])
    else $error("cpu resumed before restore");
  a_sleep_wakes: assert property (@(posedge mclk) disable iff (chipReset) // RULE7
    (mode == M_SLEEP && anyInterrupt) |=> cpuClkOn)
    else $error("interrupt did not wake sleep");
endmodule // pms_power_supervisor

/* File: pms_power_supervisor_bench.sv */
// self-checking bench for the power mode supervisor
`timescale 1ns/1ps
module pms_power_supervisor_bench;
  import pms_pkg::*;
  logic mclk, reset, supplyBelowBrown, supplyBelowWatch, optionValid, watchEnable;
  logic watchIrqClear, enterLowPower, anyInterrupt, execFromRam, flashSleepReq, useSwitcher;
  logic [2:0] optionThreshold, lowPowerSel, brownThreshold, thr;
  logic [1:0] watchEdgeSel, rangeSel, ramClkOff, ramPowerOff, coreRange, ramClkOn, ramPowerOn;
  logic [NWK-1:0] wakeSources;
  logic [NPER-1:0] busClkReq, kernelClkReq, periphActive, periphFrozen, periphPowerOn;
  logic [15:0] ioStandbyCfg, ioPadState;
  logic chipReset, watchIrq, mainRegOn, lowPowerRegOn, switcherOn, linearOn, cpuClkOn;
  logic cpuPowerOn, flashPowerOn, flashClkOn, fastRcOn, sysClkFastRc, ioStandbyHold;
  logic [3:0] modeState;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  // low-power select and range per step; stop 0 is visited again at range 2
  int selQ[$] = '{1, 2, 3, 4, 5, 6, 1};
  int rngQ[$] = '{0, 0, 0, 0, 0, 0, 2};
  pms_power_supervisor #(.NIO(8)) i_pms_power_supervisor (.mclk, .reset, .supplyBelowBrown,
    .supplyBelowWatch, .optionThreshold, .optionValid, .watchEnable, .watchEdgeSel,
    .watchIrqClear, .lowPowerSel, .enterLowPower, .rangeSel, .anyInterrupt, .wakeSources,
    .busClkReq, .kernelClkReq, .execFromRam, .flashSleepReq, .ramClkOff, .ramPowerOff,
    .ioStandbyCfg, .useSwitcher, .chipReset, .brownThreshold, .watchIrq, .modeState,
    .coreRange, .mainRegOn, .lowPowerRegOn, .switcherOn, .linearOn, .cpuClkOn, .cpuPowerOn,
    .flashPowerOn, .flashClkOn, .ramClkOn, .ramPowerOn, .periphActive, .periphFrozen,
    .periphPowerOn, .fastRcOn, .sysClkFastRc, .ioPadState, .ioStandbyHold);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic summarize;
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // model of the active set per low-power select and range
  function automatic logic [NPER-1:0] expAct(input int sel, input int rng);
    case (sel)
      1: return (rng == 2) ? ACT_STOP0_R2 : ACT_STOP0;
      2: return ACT_STOP1;
      3: return ACT_STOP2;
      4: return ACT_STOP3;
      5: return ACT_STBYRET;
      6: return ACT_STBY;
      default: return ACT_ALL;
    endcase
  endfunction
  task automatic pulse(ref logic sig);
    @(negedge mclk);
    sig = 1'b1;
    @(negedge mclk);
    sig = 1'b0;
  endtask
  task automatic enter(input int sel);
    lowPowerSel = sel[2:0];
    pulse(enterLowPower);
  endtask
  // bounded wait: restore is a fixed regulator plus clock settle count
  task automatic wake(input int bitn, output int cnt);
    cnt = 0;
    @(negedge mclk);
    wakeSources[bitn] = 1'b1;
    @(negedge mclk);
    wakeSources = '0;
    while (modeState !== M_RUN && cnt < 300)
    begin
      @(negedge mclk);
      cnt++;
    end
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      summarize();
    end
  end
  initial
  begin
    {reset, optionValid, watchIrqClear, enterLowPower, anyInterrupt} = 5'h1F & 5'h10;
    {supplyBelowBrown, supplyBelowWatch, watchEnable, execFromRam, flashSleepReq} = 5'h00;
    {optionThreshold, lowPowerSel, watchEdgeSel, rangeSel, ramClkOff, ramPowerOff} = 14'h0000;
    {wakeSources, busClkReq, kernelClkReq} = '0;
    ioStandbyCfg = 16'h0000;
    useSwitcher = 1'b0;
    void'($urandom(52));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    chk("mode after reset", M_RUN, modeState);
    chk("brown threshold", BROWN_LOWEST, brownThreshold);
    supplyBelowBrown = 1'b1;
    #1 chk("chip reset", 1, chipReset);
    @(negedge mclk);
    supplyBelowBrown = 1'b0;
    thr = 3'($urandom_range(7, 1));
    optionThreshold = thr;
    pulse(optionValid);
    @(negedge mclk);
    chk("option threshold", thr, brownThreshold);
    watchEnable = 1'b1;
    watchEdgeSel = EDGE_FALL;
    supplyBelowWatch = 1'b1;
    repeat (3) @(negedge mclk);
    chk("watch fall irq", 1, watchIrq);
    pulse(watchIrqClear);
    chk("watch cleared", 0, watchIrq);
    watchEdgeSel = EDGE_RISE;
    supplyBelowWatch = 1'b0;
    repeat (3) @(negedge mclk);
    chk("watch rise irq", 1, watchIrq);
    useSwitcher = 1'b1;
    execFromRam = 1'b1;
    flashSleepReq = 1'b1;
    repeat (3) @(negedge mclk);
    chk("switcher on", 3'b100, {switcherOn, linearOn, chipReset});
    chk("flash down", 0, {flashPowerOn, flashClkOn});
    {execFromRam, flashSleepReq} = 2'b00;
    ramClkOff = 2'b01;
    enter(SEL_SLEEP);
    chk("sleep state", {M_SLEEP, 1'b0, 2'b10}, {modeState, cpuClkOn, ramClkOn});
    pulse(anyInterrupt);
    chk("sleep wake", M_RUN, modeState);
    foreach (selQ[k])
    begin
      // range 2 only with slow clocks
      rangeSel = 2'(rngQ[k]);
      ioStandbyCfg = 16'($urandom);
      ramPowerOff = 2'($urandom);
      enter(selQ[k]);
      chk("mode", selQ[k] + 1, modeState);
      chk("active set", expAct(selQ[k], rngQ[k]), periphActive);
      chk("low power reg", selQ[k] inside {[2:5]}, lowPowerRegOn);
      chk("ram power", selQ[k] == 6 ? 2'b00 : 2'(~ramPowerOff), ramPowerOn);
      chk("core range", rngQ[k], coreRange);
      chk("cpu pads rc", {selQ[k] < 5, selQ[k] >= 5, 1'b0}, {cpuPowerOn, ioStandbyHold, fastRcOn});
      chk("power set", selQ[k] inside {3, 4} ? ACT_STOP2 : (selQ[k] >= 5 ? expAct(selQ[k], 0) : ACT_ALL), periphPowerOn);
      chk("frozen set", selQ[k] <= 2 ? NPER'(~expAct(selQ[k], rngQ[k])) : (selQ[k] == 4 ? ACT_STOP2 & ~ACT_STOP3 : '0), periphFrozen);
      if (selQ[k] >= 5)
        chk("pads", ioStandbyCfg, ioPadState);
      if (selQ[k] == 4)
      begin
        wakeSources[W_RSTPIN] = 1'b1;
        repeat (2) @(negedge mclk);
        wakeSources = '0;
        chk("stop3 masked", M_STOP3, modeState);
      end
      if (selQ[k] == 2)
      begin
        busClkReq[7] = 1'b1;
        repeat (2) @(negedge mclk);
        chk("bus req stop0", {M_STOP0, 1'b1}, {modeState, fastRcOn});
        busClkReq = '0;
        repeat (2) @(negedge mclk);
        chk("back to stop1", M_STOP1, modeState);
      end
      wake(W_WAKEPIN, n);
      chk("restore time", REG_SETTLE_CYC + CLK_SETTLE_CYC + 1, n);
      chk("after wake", 3'b111, {sysClkFastRc, cpuClkOn, mainRegOn});
    end
    summarize();
  end
endmodule // pms_power_supervisor_bench
